// file: dbt_pkg.sv
// constants and types for the data tenure controller
`default_nettype none
package dbt_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EXTACC_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ERRCNT_OFS = 8'h0C;
  localparam int CTRL_MCE_BIT = 0;
  localparam int CTRL_NORETRY_BIT = 1;
  localparam int EXTACC_BURST_BIT = 28;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int DATA_W = 64;
  localparam int PAR_W = 8;
  localparam int BEAT_W = 2;
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam logic [2:0] SINGLE_BEATS = 3'h1;
  localparam logic [31:0] DW_MASK = 32'hFFFF_FFF8;
  localparam logic [31:0] LINE_MASK = 32'hFFFF_FFE0;
  localparam logic [1:0] DONE_OK = 2'h0;
  localparam logic [1:0] DONE_ERR = 2'h1;
  localparam logic [1:0] DONE_RETRY = 2'h2;
  localparam int SNP_LINES = 4;
  localparam int SNP_IDX_LO = 5;
  localparam int SNP_TAG_LO = 7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_GRANT = 3'b001,
    ST_XFER = 3'b010,
    ST_CHECK = 3'b011,
    ST_HOLD = 3'b100,
    ST_GAP = 3'b101
  } dbt_state_e;
  typedef enum logic [1:0] {
    LN_INVALID = 2'b00,
    LN_EXCLUSIVE = 2'b01,
    LN_MODIFIED = 2'b10
  } dbt_line_e;
endpackage
`default_nettype wire

// file: dbt_beat_mem.sv
// four-beat write data store with registered read port
`default_nettype none
module dbt_beat_mem (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [dbt_pkg::BEAT_W-1:0] wrIdx,
  input wire logic [dbt_pkg::DATA_W+dbt_pkg::PAR_W-1:0] wrWord,
  input wire logic [dbt_pkg::BEAT_W-1:0] rdIdx,
  output logic [dbt_pkg::DATA_W+dbt_pkg::PAR_W-1:0] rdWord
);
  localparam int WORD_W = dbt_pkg::DATA_W + dbt_pkg::PAR_W;
  logic [WORD_W-1:0] mem [0:(1<<dbt_pkg::BEAT_W)-1];

  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrWord;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdWord <= '0;
    end
    else
    begin
      rdWord <= mem[rdIdx];
    end
  end
endmodule
`default_nettype wire

// file: dbt_snoop.sv
// snoop qualification and line state tracking
`default_nettype none
module dbt_snoop (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic addrBusMaster,
  input wire logic transferStartIn,
  input wire logic globalSnoopIn,
  input wire logic [31:0] snoopAddr,
  input wire logic lineFillValid,
  input wire logic [31:0] lineFillAddr,
  input wire logic lineFillDirty,
  output logic snoopHit,
  output logic snoopPush
);
  localparam int IW = $clog2(dbt_pkg::SNP_LINES);
  localparam int TW = 32 - dbt_pkg::SNP_TAG_LO;
  logic [TW-1:0] tagMem [0:dbt_pkg::SNP_LINES-1];
  dbt_pkg::dbt_line_e lineState [0:dbt_pkg::SNP_LINES-1];
  logic qualified, hit;
  logic [IW-1:0] sIdx, fIdx;

  assign sIdx = snoopAddr[dbt_pkg::SNP_IDX_LO +: IW];
  assign fIdx = lineFillAddr[dbt_pkg::SNP_IDX_LO +: IW];
  assign qualified = !addrBusMaster && transferStartIn && globalSnoopIn;
  assign hit = qualified && lineState[sIdx] != dbt_pkg::LN_INVALID &&
    tagMem[sIdx] == snoopAddr[31:dbt_pkg::SNP_TAG_LO];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      snoopHit <= 1'b0;
      snoopPush <= 1'b0;
      for (int i = 0; i < dbt_pkg::SNP_LINES; i++)
      begin
        lineState[i] <= dbt_pkg::LN_INVALID;
        tagMem[i] <= '0;
      end
    end
    else
    begin
      snoopHit <= hit;
      snoopPush <= hit && lineState[sIdx] == dbt_pkg::LN_MODIFIED;
      if (lineFillValid)
      begin
        tagMem[fIdx] <= lineFillAddr[31:dbt_pkg::SNP_TAG_LO];
        lineState[fIdx] <= lineFillDirty ? dbt_pkg::LN_MODIFIED :
          dbt_pkg::LN_EXCLUSIVE;
      end
      if (hit)
      begin
        lineState[sIdx] <= dbt_pkg::LN_INVALID;
      end
    end
  end

  snoop_qual_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(transferStartIn && globalSnoopIn) |=> !snoopHit)
    else $error("snoop hit without qualified snoop");
endmodule
`default_nettype wire

// file: dbt_tenure.sv
// data tenure controller: bus master data phase, apb control, snoop
// Contract
// - data moves on two 32-bit halves plus eight parity lines.
// - single beats carry 1 to 8 bytes; bursts carry eight words.
// - burst indicator marks bursts, or external access bit 28 for ext ops.
// - critical misses start at doubleword address, other bursts at line.
// - read retry cancels previous beat; the beat waits for new ack.
// - retry after last beat: release busy, keep beat pending.
// - read retry is ignored during write tenures.
// - busy is negated for one cycle after final termination.
// - bus error ends the tenure at once, later acks ignored.
// - bus error gives machine check if enabled, else checkstop.
// - address retry for this tenure ends it immediately.
// - single beat ends on acknowledge; writes never sample retry.
// - burst ends after four acknowledges, not necessarily consecutive.
// - bus stays held while read retry is asserted.
// - global output follows the coherency page attribute.
// - snoop only when start and global coincide.
// - qualified snoop compares tags and updates line state on hit.
// - grant qualified only with busy, retries negated.
// - no-retry mode forwards read data on acknowledge.
`default_nettype none
module dbt_tenure (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqBurst,
  input wire logic reqCritical,
  input wire logic reqCoherent,
  input wire logic reqExtCtl,
  input wire logic [31:0] reqAddr,
  output logic reqReady,
  input wire logic fillValid,
  input wire logic [1:0] fillIdx,
  input wire logic [63:0] fillData,
  input wire logic [7:0] fillParity,
  output logic fwdValid,
  output logic [63:0] fwdData,
  output logic [7:0] fwdParity,
  output logic doneValid,
  output logic [1:0] doneStatus,
  output logic machineCheck,
  output logic checkstop,
  output logic [31:0] txAddr,
  output logic burstIndicator,
  output logic globalSnoopOut,
  input wire logic dbusGrant,
  input wire logic dbusBusyIn,
  output logic dbusBusyOut,
  output logic dbusBusyOe,
  input wire logic addrRetry,
  input wire logic beatAck,
  input wire logic readBeatRetry,
  input wire logic busErrorAck,
  input wire logic [31:0] dataHighIn,
  input wire logic [31:0] dataLowIn,
  input wire logic [7:0] dataParityIn,
  output logic [31:0] dataHighOut,
  output logic [31:0] dataLowOut,
  output logic [7:0] dataParityOut,
  output logic dataOe,
  input wire logic addrBusMaster,
  input wire logic transferStartIn,
  input wire logic globalSnoopIn,
  input wire logic [31:0] snoopAddr,
  input wire logic lineFillValid,
  input wire logic [31:0] lineFillAddr,
  input wire logic lineFillDirty,
  output logic snoopHit,
  output logic snoopPush
);
  dbt_pkg::dbt_state_e state, next_state;
  logic [31:0] ctrl, next_ctrl, extAccess, next_extAccess;
  logic [31:0] errCnt, next_errCnt;
  logic isWrite, next_isWrite, isBurst, next_isBurst;
  logic [2:0] ackCnt, next_ackCnt, cntEff;
  logic pend, next_pend, busyDrv, next_busyDrv;
  logic [71:0] stage, next_stage, memWord;
  logic next_fwdValid, next_doneValid, next_reqReady;
  logic [71:0] next_fwd;
  logic [1:0] next_doneStatus;
  logic next_machineCheck, next_checkstop, next_oe;
  logic [31:0] next_txAddr, next_prdata;
  logic next_burstInd, next_global, next_pready, next_pslverr;
  logic qualGrant, mce, noRetry, drop, errEv, accept, apbWr;
  logic [2:0] total;

  assign mce = ctrl[dbt_pkg::CTRL_MCE_BIT];
  assign noRetry = ctrl[dbt_pkg::CTRL_NORETRY_BIT];
  assign total = isBurst ? dbt_pkg::BURST_BEATS : dbt_pkg::SINGLE_BEATS;
  assign accept = reqValid && reqReady;
  assign qualGrant = dbusGrant && !dbusBusyIn && !readBeatRetry &&
    !addrRetry;
  // retry drops the staged read beat only
  assign drop = pend && readBeatRetry && !isWrite;
  assign cntEff = ackCnt - {2'b00, drop};
  // error during busy or read check window
  assign errEv = busErrorAck && (busyDrv || state == dbt_pkg::ST_CHECK ||
    state == dbt_pkg::ST_HOLD);
  assign apbWr = psel && penable && pready && pwrite;

  // write beats held in the beat store
  dbt_beat_mem beatMem (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(fillValid),
    .wrIdx(fillIdx),
    .wrWord({fillParity, fillData}),
    .rdIdx(next_ackCnt[1:0]),
    .rdWord(memWord)
  );

  dbt_snoop snoop (
    .ref_clk(ref_clk),
    .rst(rst),
    .addrBusMaster(addrBusMaster),
    .transferStartIn(transferStartIn),
    .globalSnoopIn(globalSnoopIn),
    .snoopAddr(snoopAddr),
    .lineFillValid(lineFillValid),
    .lineFillAddr(lineFillAddr),
    .lineFillDirty(lineFillDirty),
    .snoopHit(snoopHit),
    .snoopPush(snoopPush)
  );

  assign {dataParityOut, dataHighOut, dataLowOut} = memWord;

  always_comb
  begin
    next_state = state;
    next_isWrite = isWrite;
    next_isBurst = isBurst;
    next_ackCnt = ackCnt;
    next_pend = 1'b0;
    next_stage = stage;
    next_fwdValid = 1'b0;
    next_fwd = {fwdParity, fwdData};
    next_doneValid = 1'b0;
    next_doneStatus = doneStatus;
    next_machineCheck = 1'b0;
    next_checkstop = checkstop;
    next_errCnt = errCnt;
    next_txAddr = txAddr;
    next_burstInd = burstIndicator;
    next_global = globalSnoopOut;
    case (state)
      dbt_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          next_isWrite = reqWrite;
          next_isBurst = reqBurst;
          next_ackCnt = '0;
          // burst flag or external access bit
          next_burstInd = reqExtCtl ?
            extAccess[dbt_pkg::EXTACC_BURST_BIT] : reqBurst;
          next_txAddr = !reqBurst ? reqAddr :
            (reqCritical ? (reqAddr & dbt_pkg::DW_MASK) :
            (reqAddr & dbt_pkg::LINE_MASK));
          next_global = reqCoherent;
          next_state = dbt_pkg::ST_WAIT_GRANT;
        end
      end
      dbt_pkg::ST_WAIT_GRANT:
      begin
        if (addrRetry)
        begin
          next_doneValid = 1'b1;
          next_doneStatus = dbt_pkg::DONE_RETRY;
          next_state = dbt_pkg::ST_IDLE;
        end
        else if (qualGrant)
        begin
          next_state = dbt_pkg::ST_XFER;
        end
      end
      dbt_pkg::ST_XFER, dbt_pkg::ST_CHECK, dbt_pkg::ST_HOLD:
      begin
        next_ackCnt = cntEff;
        // confirmed beat goes to the core
        if (pend && !drop && !isWrite)
        begin
          next_fwdValid = 1'b1;
          next_fwd = stage;
        end
        if (errEv)
        begin
          next_errCnt = errCnt + 32'h1;
          next_doneValid = 1'b1;
          next_doneStatus = dbt_pkg::DONE_ERR;
          next_machineCheck = mce;
          next_checkstop = checkstop || !mce;
          next_state = dbt_pkg::ST_GAP;
        end
        else if (addrRetry && state == dbt_pkg::ST_XFER)
        begin
          next_doneValid = 1'b1;
          next_doneStatus = dbt_pkg::DONE_RETRY;
          next_state = dbt_pkg::ST_GAP;
        end
        else if (state == dbt_pkg::ST_CHECK && !drop)
        begin
          next_doneValid = 1'b1;
          next_doneStatus = dbt_pkg::DONE_OK;
          next_state = dbt_pkg::ST_IDLE;
        end
        else if (state == dbt_pkg::ST_CHECK)
        begin
          // last beat retried, busy stays off
          next_state = dbt_pkg::ST_HOLD;
        end
        else if (beatAck)
        begin
          next_ackCnt = cntEff + 3'h1;
          if (!isWrite && noRetry)
          begin
            // forward at once in no-retry mode
            next_fwdValid = 1'b1;
            next_fwd = {dataParityIn, dataHighIn, dataLowIn};
          end
          else if (!isWrite)
          begin
            next_pend = 1'b1;
            next_stage = {dataParityIn, dataHighIn, dataLowIn};
          end
          if (cntEff == total - 3'h1)
          begin
            if (!isWrite && !noRetry)
            begin
              next_state = dbt_pkg::ST_CHECK;
            end
            else
            begin
              next_doneValid = 1'b1;
              next_doneStatus = dbt_pkg::DONE_OK;
              next_state = dbt_pkg::ST_GAP;
            end
          end
        end
      end
      default:
      begin
        next_state = dbt_pkg::ST_IDLE;
      end
    endcase
    // busy only in the transfer state
    next_busyDrv = next_state == dbt_pkg::ST_XFER;
    next_oe = next_busyDrv && next_isWrite;
    next_reqReady = next_state == dbt_pkg::ST_IDLE && !accept;
  end

  always_comb
  begin
    next_ctrl = ctrl;
    next_extAccess = extAccess;
    next_prdata = prdata;
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    if (apbWr && paddr == dbt_pkg::CTRL_OFS)
    begin
      next_ctrl = pwdata;
    end
    else if (apbWr && paddr == dbt_pkg::EXTACC_OFS)
    begin
      next_extAccess = pwdata;
    end
    if (psel && !penable)
    begin
      if (paddr == dbt_pkg::CTRL_OFS)
      begin
        next_prdata = ctrl;
      end
      else if (paddr == dbt_pkg::EXTACC_OFS)
      begin
        next_prdata = extAccess;
      end
      else if (paddr == dbt_pkg::STATUS_OFS)
      begin
        next_prdata = {22'h0, busyDrv, checkstop, 1'b0, ackCnt,
          1'b0, state};
      end
      else if (paddr == dbt_pkg::ERRCNT_OFS)
      begin
        next_prdata = errCnt;
      end
      else
      begin
        next_prdata = '0;
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= dbt_pkg::ST_IDLE;
      ctrl <= dbt_pkg::CTRL_RESET;
      extAccess <= '0;
      errCnt <= '0;
      isWrite <= 1'b0;
      isBurst <= 1'b0;
      ackCnt <= '0;
      pend <= 1'b0;
      stage <= '0;
      busyDrv <= 1'b0;
      dataOe <= 1'b0;
      reqReady <= 1'b0;
      fwdValid <= 1'b0;
      {fwdParity, fwdData} <= '0;
      doneValid <= 1'b0;
      doneStatus <= dbt_pkg::DONE_OK;
      machineCheck <= 1'b0;
      checkstop <= 1'b0;
      txAddr <= '0;
      burstIndicator <= 1'b0;
      globalSnoopOut <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ctrl <= next_ctrl;
      extAccess <= next_extAccess;
      errCnt <= next_errCnt;
      isWrite <= next_isWrite;
      isBurst <= next_isBurst;
      ackCnt <= next_ackCnt;
      pend <= next_pend;
      stage <= next_stage;
      busyDrv <= next_busyDrv;
      dataOe <= next_oe;
      reqReady <= next_reqReady;
      fwdValid <= next_fwdValid;
      {fwdParity, fwdData} <= next_fwd;
      doneValid <= next_doneValid;
      doneStatus <= next_doneStatus;
      machineCheck <= next_machineCheck;
      checkstop <= next_checkstop;
      txAddr <= next_txAddr;
      burstIndicator <= next_burstInd;
      globalSnoopOut <= next_global;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign dbusBusyOut = busyDrv;
  assign dbusBusyOe = busyDrv;

  sequence waitGrantQ;
    state == dbt_pkg::ST_WAIT_GRANT && qualGrant;
  endsequence
  sequence lastReadAck;
    state == dbt_pkg::ST_XFER && !isWrite && !noRetry && beatAck &&
      !busErrorAck && !addrRetry && !drop && ackCnt == total - 3'h1;
  endsequence

  busy_after_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
    waitGrantQ |=> busyDrv)
    else $error("busy not raised after qualified grant");
  grant_busy_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == dbt_pkg::ST_WAIT_GRANT && dbusBusyIn |=> !busyDrv)
    else $error("grant taken while bus busy");
  error_ends_a: assert property (@(posedge ref_clk) disable iff (rst)
    busyDrv && busErrorAck |=> !busyDrv && doneValid &&
      doneStatus == dbt_pkg::DONE_ERR ##1 state == dbt_pkg::ST_IDLE)
    else $error("bus error did not end tenure");
  error_exception_a: assert property (@(posedge ref_clk) disable iff (rst)
    errEv |=> (machineCheck == $past(mce)) && (checkstop || $past(mce)))
    else $error("wrong exception on bus error");
  addr_retry_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == dbt_pkg::ST_XFER && addrRetry && !busErrorAck |=>
      !busyDrv && doneStatus == dbt_pkg::DONE_RETRY)
    else $error("address retry did not cancel tenure");
  busy_gap_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(busyDrv) |-> !busyDrv ##1 !busyDrv)
    else $error("busy not negated for a cycle");
  last_retry_a: assert property (@(posedge ref_clk) disable iff (rst)
    lastReadAck ##1 (readBeatRetry && !busErrorAck) |=>
      state == dbt_pkg::ST_HOLD && !busyDrv && !doneValid)
    else $error("retried last beat not kept pending");
  write_no_retry_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == dbt_pkg::ST_XFER && isWrite && isBurst && beatAck &&
      !busErrorAck && !addrRetry |=> ackCnt == $past(ackCnt) + 3'h1)
    else $error("write beat count disturbed");
  burst_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    accept && !reqExtCtl |=> burstIndicator == $past(reqBurst))
    else $error("burst indicator mismatch");
  line_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    accept && reqBurst && !reqCritical |=> txAddr[4:0] == 5'h00)
    else $error("burst not line aligned");
  fast_forward_a: assert property (@(posedge ref_clk) disable iff (rst)
    state == dbt_pkg::ST_XFER && !isWrite && noRetry && beatAck &&
      !busErrorAck && !addrRetry |=> fwdValid)
    else $error("no-retry mode did not forward");
endmodule
`default_nettype wire

// file: dbt_mem_model.sv
// memory controller model answering the data tenure with acks, retries, errors and data
`default_nettype none
module dbt_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic arm,
  input wire logic [2:0] nBeats,
  input wire logic [1:0] ackDelay,
  input wire logic [2:0] retryAt,
  input wire logic [2:0] errAt,
  input wire logic dbusBusyOut,
  input wire logic dataOe,
  output logic beatAck,
  output logic readBeatRetry,
  output logic busErrorAck,
  output logic [31:0] dataHighIn,
  output logic [31:0] dataLowIn,
  output logic [7:0] dataParityIn
);
  logic [2:0] acks;
  logic [1:0] waitCnt;
  logic pend;
  logic retried;
  logic isRead;
  logic badBeat;

  // beat that will be cancelled carries junk
  assign badBeat = !retried && retryAt == acks + 3'h1;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {beatAck, readBeatRetry, busErrorAck, pend, retried, isRead} <= '0;
      {acks, waitCnt, dataHighIn, dataLowIn, dataParityIn} <= '0;
    end
    else
    begin
      beatAck <= 1'h0;
      readBeatRetry <= 1'h0;
      busErrorAck <= 1'h0;
      {dataHighIn, dataLowIn, dataParityIn} <=
        ~{dataHighIn, dataLowIn, dataParityIn};
      if (arm)
        {acks, waitCnt, pend, retried} <= '0;
      else if (beatAck && !retried && retryAt == acks)
      begin
        readBeatRetry <= 1'h1;
        retried <= 1'h1;
        pend <= isRead;
        if (isRead)
          acks <= acks - 3'h1;
      end
      else if ((dbusBusyOut || pend) && acks < nBeats)
      begin
        waitCnt <= waitCnt + 2'h1;
        if (waitCnt == ackDelay)
        begin
          waitCnt <= 2'h0;
          pend <= 1'h0;
          isRead <= !dataOe;
          beatAck <= acks != errAt;
          busErrorAck <= acks == errAt;
          acks <= acks == errAt ? nBeats : acks + 3'h1;
          dataHighIn <= badBeat ? 32'hDEAD_BEEF : 32'hA5A5_0000 + acks;
          dataLowIn <= 32'h5A5A_0000 + acks;
          dataParityIn <= 8'hF0 + acks;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dbt_tenure_bench.sv
// self-checking bench for the data tenure controller
`default_nettype none
module dbt_tenure_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [5:0] f;
    logic [31:0] addr;
    logic [1:0] dly;
    logic [2:0] rtry;
    logic [2:0] err;
    logic [31:0] expAddr;
    logic [1:0] expStat;
    logic [2:0] expFwd;
  } dbt_row_s;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic psel, penable, pwrite, pready, pslverr, reqValid, reqWrite, reqBurst;
  logic reqCritical, reqCoherent, reqExtCtl, reqReady, fillValid, fwdValid;
  logic doneValid, machineCheck, checkstop, burstIndicator, globalSnoopOut;
  logic dbusGrant, dbusBusyIn, dbusBusyOut, dbusBusyOe, addrRetry, beatAck;
  logic readBeatRetry, busErrorAck, dataOe, addrBusMaster, transferStartIn;
  logic globalSnoopIn, lineFillValid, lineFillDirty, snoopHit, snoopPush;
  logic arm, slvErr;
  logic [1:0] fillIdx, doneStatus, ackDelay;
  logic [2:0] nBeats, retryAt, errAt, fwdCount, mcCount;
  logic [7:0] paddr, fillParity, fwdParity, dataParityIn, dataParityOut;
  logic [31:0] pwdata, prdata, reqAddr, txAddr, dataHighIn, dataLowIn;
  logic [31:0] dataHighOut, dataLowOut, snoopAddr, lineFillAddr, rdq;
  logic [63:0] fillData, fwdData;
  int badCount = 0;
  int comparisons = 0;
  // flags: write, burst, critical, coherent, ext op, address retry
  dbt_row_s rows [8] = '{
    '{6'h04, 32'h1234, 2'h0, 3'h0, 3'h7, 32'h1234, 2'h0, 3'h1},
    '{6'h18, 32'h1234, 2'h2, 3'h0, 3'h7, 32'h1230, 2'h0, 3'h4},
    '{6'h14, 32'h1234, 2'h0, 3'h2, 3'h7, 32'h1220, 2'h0, 3'h4},
    '{6'h30, 32'h2238, 2'h0, 3'h1, 3'h7, 32'h2220, 2'h0, 3'h0},
    '{6'h00, 32'h3000, 2'h1, 3'h1, 3'h7, 32'h3000, 2'h0, 3'h1},
    '{6'h10, 32'h4000, 2'h1, 3'h0, 3'h2, 32'h4000, 2'h1, 3'h2},
    '{6'h01, 32'h5000, 2'h0, 3'h0, 3'h7, 32'h5000, 2'h2, 3'h0},
    '{6'h02, 32'h6004, 2'h0, 3'h0, 3'h7, 32'h6004, 2'h0, 3'h1}
  };

  always #12.5 ref_clk = ~ref_clk;

  dbt_tenure dut (.*);
  dbt_mem_model partner (.*);

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rdq = prdata;
    slvErr = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic run(input int i, input logic hold);
    dbt_row_s r;
    r = rows[i];
    if (r.f[5])
      for (int k = 0; k < 4; k++)
      begin
        @(posedge ref_clk);
        {fillValid, fillIdx, fillParity} <= {1'h1, k[1:0], k[7:0]};
        fillData <= {2{32'hC0C0_0000 + k}};
      end
    @(posedge ref_clk);
    fillValid <= 1'h0;
    {reqWrite, reqBurst, reqCritical, reqCoherent, reqExtCtl} <= r.f[5:1];
    {reqValid, reqAddr, dbusBusyIn} <= {1'h1, r.addr, hold};
    {arm, nBeats, ackDelay, retryAt, errAt} <=
      {1'h1, r.f[4] ? 3'h4 : 3'h1, r.dly, r.rtry, r.err};
    fwdCount = 3'h0;
    mcCount = 3'h0;
    do @(posedge ref_clk); while (reqReady !== 1'h1);
    {reqValid, arm, addrRetry} <= {2'h0, r.f[0]};
    @(posedge ref_clk);
    addrRetry <= 1'h0;
    if (hold)
    begin
      repeat (4) @(posedge ref_clk);
      check(dbusBusyOut, 1'h0);
      check(dbusBusyOe, 1'h0);
      dbusBusyIn <= 1'h0;
    end
    do @(posedge ref_clk); while (doneValid !== 1'h1);
    check(doneStatus, r.expStat);
    @(posedge ref_clk);
    check(fwdCount, r.expFwd);
    check(txAddr, r.expAddr);
    check(burstIndicator, r.f[4] | r.f[1]);
    check(globalSnoopOut, r.f[2]);
    if (r.f[5])
      check({dataParityOut, dataHighOut, dataLowOut},
        72'h00_C0C0_0000_C0C0_0000);
    $display("test %0d done", i);
  endtask

  task automatic snoop(input logic glob, input logic [1:0] exp);
    @(posedge ref_clk);
    {transferStartIn, globalSnoopIn, snoopAddr} <= {1'h1, glob, 32'h440};
    @(posedge ref_clk);
    {transferStartIn, globalSnoopIn} <= 2'h0;
    @(posedge ref_clk);
    check({snoopHit, snoopPush}, exp);
    $display("snoop test done");
  endtask

  // confirmed read beats arrive in order
  always @(posedge ref_clk)
  begin
    if (fwdValid === 1'h1)
    begin
      check({fwdData, fwdParity}, {32'hA5A5_0000 + fwdCount,
        32'h5A5A_0000 + fwdCount, 8'hF0 + fwdCount});
      fwdCount <= fwdCount + 3'h1;
    end
    if (machineCheck === 1'h1)
      mcCount <= mcCount + 3'h1;
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, arm, reqAddr} = '0;
    {reqValid, reqWrite, reqBurst, reqCritical, reqCoherent, reqExtCtl} = '0;
    {fillValid, fillIdx, fillData, fillParity, nBeats, ackDelay} = '0;
    {retryAt, errAt, dbusBusyIn, addrRetry, addrBusMaster} = '0;
    {transferStartIn, globalSnoopIn, snoopAddr, lineFillValid} = '0;
    {lineFillAddr, lineFillDirty, fwdCount, mcCount} = '0;
    dbusGrant = 1'h1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    apb(1'h1, dbt_pkg::EXTACC_OFS, 32'h1000_0000);
    for (int i = 0; i < 8; i++)
    begin
      run(i, 1'h0);
      check(mcCount, {2'h0, rows[i].expStat == 2'h1});
    end
    apb(1'h0, dbt_pkg::CTRL_OFS, 32'h0);
    check(rdq, dbt_pkg::CTRL_RESET);
    apb(1'h0, 8'h10, 32'h0);
    check({slvErr, rdq}, 33'h1_0000_0000);
    run(0, 1'h1);
    apb(1'h1, dbt_pkg::CTRL_OFS, 32'h2);
    run(1, 1'h0);
    @(posedge ref_clk);
    {lineFillValid, lineFillAddr, lineFillDirty} <= {1'h1, 32'h440, 1'h1};
    @(posedge ref_clk);
    lineFillValid <= 1'h0;
    snoop(1'h0, 2'h0);
    snoop(1'h1, 2'h3);
    snoop(1'h1, 2'h0);
    apb(1'h1, dbt_pkg::CTRL_OFS, 32'h0);
    run(5, 1'h0);
    check({mcCount, checkstop}, 4'h1);
    stopTest();
  end

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    badCount++;
    stopTest();
  end
endmodule
`default_nettype wire
